// ==== rtl/pcs_config_status_register.sv ====
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "pcs_cfg_defs.svh"

module pcs_config_status_register
#(
  parameter int unsigned DESC_SHORT_CYC = `PCS_DESC_SHORT_CYC,
  parameter int unsigned DESC_LONG_CYC  = `PCS_DESC_LONG_CYC
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   fiber_strap,
  input  wire logic                   external_force_link_input,
  input  wire logic                   signal_level_valid,
  input  wire logic                   descrambler_locked,
  input  wire logic                   descrambler_sync_seen,
  output pcs_cfg_pkg::pcs_ctrl_t      pcs_ctrl,
  output logic                        force_good_link,
  output logic                        link_up,
  output logic                        descrambler_timeout
);

  import pcs_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  logic [2:0]  strap_sync_r;
  logic [2:0]  force_sync_r;
  logic        strap_lvl_r;
  logic        force_lvl_r;
  logic [2:0]  settle_cnt_r;
  logic        strap_loaded_r;
  logic [15:0] cfg_r;
  logic        access_ok;
  logic        addr_hit;
  logic [15:0] read_word;
  link_state_t link_state_r;
  link_state_t link_state_nxt;
  logic        level_ok;
  logic [31:0] desc_cnt_r;
  logic [31:0] desc_limit;

  // Three-stage shift registers for the two asynchronous pins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_sync_r <= 3'h0;
      force_sync_r <= 3'h0;
    end
    else
    begin
      strap_sync_r <= {strap_sync_r[1:0], fiber_strap};
      force_sync_r <= {force_sync_r[1:0], external_force_link_input};
    end
  end

  // A level change counts once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_lvl_r <= 1'b0;
      force_lvl_r <= 1'b0;
    end
    else
    begin
      if (strap_sync_r[1] == strap_sync_r[2])
        strap_lvl_r <= strap_sync_r[2];
      if (force_sync_r[1] == force_sync_r[2])
        force_lvl_r <= force_sync_r[2];
    end
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------

  // Waits after reset release until the filtered strap level is valid.
  // The filtered level needs four edges, so the load happens on the fifth.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle_cnt_r   <= 3'h0;
      strap_loaded_r <= 1'b0;
    end
    else if (!strap_loaded_r)
    begin
      if (settle_cnt_r == `PCS_STRAP_SETTLE)
        strap_loaded_r <= 1'b1;
      else
        settle_cnt_r <= settle_cnt_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------

  // A request is completed in the second access cycle.
  assign access_ok = psel & penable & pready;
  assign addr_hit  = (paddr[`PCS_ADDR_W-1:0] == `PCS_CFG_ADDR) &&
                     (paddr[31:`PCS_ADDR_W] == '0);

  // Read view of the register; the reserved bit 4 always reads zero.
  always_comb
  begin
    read_word = cfg_r;
    read_word[`PCS_RSVD_LO_BIT] = 1'b0;
  end

  // Handshake: pready rises one cycle into the access phase, held off
  // until the strap defaults are in place.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else if (psel && penable && !pready && strap_loaded_r)
    begin
      pready  <= 1'b1;
      pslverr <= !addr_hit;
      prdata  <= (!pwrite && addr_hit) ? {16'h0, read_word} : 32'h0;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------

  // Strap bits load once; software writes land on the completing edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_r <= `PCS_RESET_VALUE;
    else if (!strap_loaded_r && settle_cnt_r == `PCS_STRAP_SETTLE)
    begin
      if (strap_lvl_r)
        cfg_r <= `PCS_RESET_VALUE | `PCS_STRAP_MASK;
      else
        cfg_r <= `PCS_RESET_VALUE;
    end
    else if (access_ok && pwrite && addr_hit)
    begin
      cfg_r <= pwdata[15:0] & `PCS_WRITE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------

  // Registered copies of the control fields for the datapath.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pcs_ctrl        <= '0;
      force_good_link <= 1'b0;
    end
    else
    begin
      pcs_ctrl.rx_clk_free_run        <= cfg_r[`PCS_FREE_CLK_BIT];
      pcs_ctrl.quiet_transmit_enable  <= cfg_r[`PCS_QUIET_BIT];
      pcs_ctrl.signal_detect_override <= cfg_r[`PCS_SD_FORCE_BIT];
      pcs_ctrl.fiber_mode_enable      <= cfg_r[`PCS_FIBER_BIT];
      pcs_ctrl.far_end_fault_enable   <= cfg_r[`PCS_FEFI_BIT];
      pcs_ctrl.nrzi_skip              <= cfg_r[`PCS_NRZI_BIT];
      pcs_ctrl.tx_scramble_skip       <= cfg_r[`PCS_SCRAM_BIT];
      pcs_ctrl.rx_descramble_skip     <= cfg_r[`PCS_DESCRAM_BIT];
      force_good_link <= cfg_r[`PCS_FORCE_LINK_BIT] | force_lvl_r;
    end
  end

  // ----------------------------------------------------------------
  // Link maintenance
  // ----------------------------------------------------------------

  // The detect override makes the signal level count as valid.
  assign level_ok = signal_level_valid | cfg_r[`PCS_SD_FORCE_BIT];

  // Next link state from level, lock and the selected hold algorithm.
  always_comb
  begin
    link_state_nxt = link_state_r;
    unique case (link_state_r)
      LINK_DOWN:
      begin
        if (level_ok && descrambler_locked)
          link_state_nxt = LINK_UP;
      end
      LINK_UP:
      begin
        if (cfg_r[`PCS_LINK_ALG_BIT])
        begin
          if (!level_ok)
            link_state_nxt = LINK_DOWN;
        end
        else if (!level_ok || !descrambler_locked)
          link_state_nxt = LINK_DOWN;
      end
    endcase
  end

  // Link state and the link output, which a forced link overrides.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_state_r <= LINK_DOWN;
      link_up      <= 1'b0;
    end
    else
    begin
      link_state_r <= link_state_nxt;
      link_up <= (link_state_nxt == LINK_UP) | force_good_link;
    end
  end

  // ----------------------------------------------------------------
  // Descrambler timeout
  // ----------------------------------------------------------------

  assign desc_limit = cfg_r[`PCS_DESCRAMBLER_TIMEOUT_SELECT_BIT] ? DESC_LONG_CYC : DESC_SHORT_CYC;

  // Counts cycles since the last sync event, unlocked cycle or timeout pulse; pulses once on each expiry and restarts the count.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      desc_cnt_r          <= 32'h0;
      descrambler_timeout <= 1'b0;
    end
    else if (descrambler_sync_seen || !descrambler_locked)
    begin
      desc_cnt_r          <= 32'h0;
      descrambler_timeout <= 1'b0;
    end
    else if (desc_cnt_r + 32'h1 >= desc_limit)
    begin
      desc_cnt_r          <= 32'h0;
      descrambler_timeout <= 1'b1;
    end
    else
    begin
      desc_cnt_r          <= desc_cnt_r + 32'h1;
      descrambler_timeout <= 1'b0;
    end
  end

endmodule // pcs_config_status_register

// ==== rtl/pcs_cfg_defs.svh ====
`ifndef PCS_CFG_DEFS_SVH
`define PCS_CFG_DEFS_SVH

// APB address of the register: printed index times four.
`define PCS_CFG_IDX          12'h016
`define PCS_CFG_ADDR         (`PCS_CFG_IDX << 2)
`define PCS_ADDR_W           12

// Field positions.
`define PCS_RSVD_HI_MSB      15
`define PCS_RSVD_HI_LSB      12
`define PCS_FREE_CLK_BIT     11
`define PCS_QUIET_BIT        10
`define PCS_SD_FORCE_BIT     9
`define PCS_LINK_ALG_BIT     8
`define PCS_DESCRAMBLER_TIMEOUT_SELECT_BIT    7
`define PCS_FIBER_BIT        6
`define PCS_FORCE_LINK_BIT   5
`define PCS_RSVD_LO_BIT      4
`define PCS_FEFI_BIT         3
`define PCS_NRZI_BIT         2
`define PCS_SCRAM_BIT        1
`define PCS_DESCRAM_BIT      0

// Reset value without strap, and the bits that follow the fiber strap.
`define PCS_RESET_VALUE      16'h0100
`define PCS_STRAP_MASK       16'h004B
// Writable bits; bit 4 is read-only zero.
`define PCS_WRITE_MASK       16'hFFEF

// Descrambler timeouts and the clock period in nanoseconds, then the timeouts in clock cycles.
`define PCS_CLK_PERIOD_NS    5
`define PCS_DESC_SHORT_NS    722000
`define PCS_DESC_LONG_NS     2000000
`define PCS_DESC_SHORT_CYC   (`PCS_DESC_SHORT_NS / `PCS_CLK_PERIOD_NS)
`define PCS_DESC_LONG_CYC    (`PCS_DESC_LONG_NS / `PCS_CLK_PERIOD_NS)

// Cycles until the synchronised strap level is valid after reset.
`define PCS_STRAP_SETTLE     3'h4

`endif

// ==== rtl/pcs_cfg_pkg.sv ====
package pcs_cfg_pkg;

  // Control levels handed to the PCS datapath.
  typedef struct packed {
    logic rx_clk_free_run;
    logic quiet_transmit_enable;
    logic signal_detect_override;
    logic fiber_mode_enable;
    logic far_end_fault_enable;
    logic nrzi_skip;
    logic tx_scramble_skip;
    logic rx_descramble_skip;
  } pcs_ctrl_t;

  // Link state.
  typedef enum logic [0:0] {
    LINK_DOWN = 1'b0,
    LINK_UP   = 1'b1
  } link_state_t;

endpackage

// ==== tb/pcs_config_status_register_asserts.sv ====
`timescale 1ns/10ps
`include "pcs_cfg_defs.svh"
// ----------------------------------------
// Port checker for the PCS register block
// ----------------------------------------
module pcs_cfg_checker
  import pcs_cfg_pkg::*;
#(
  parameter int unsigned DESC_SHORT_CYC = 20,
  parameter int unsigned DESC_LONG_CYC  = 50
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fiber_strap,
  input wire logic        external_force_link_input,
  input wire logic        signal_level_valid,
  input wire logic        descrambler_locked,
  input wire logic        descrambler_sync_seen,
  input wire pcs_ctrl_t   pcs_ctrl,
  input wire logic        force_good_link,
  input wire logic        link_up,
  input wire logic        descrambler_timeout
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A completed bus transfer, and a link with nothing keeping it up.
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_no_level;
    (!signal_level_valid && !pcs_ctrl.signal_detect_override && !force_good_link) [*4];
  endsequence

  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  chk_slave_error: assert property (s_done |-> pslverr == (paddr != 32'(`PCS_CFG_ADDR)))
    else $error("pslverr does not match the address");
  chk_read_zero: assert property (s_done ##0 !pwrite |-> prdata[31:16] == 16'h0 && !prdata[4])
    else $error("unused read bits not zero");
  chk_ext_force: assert property (external_force_link_input [*6] |-> ##1 force_good_link)
    else $error("external force did not reach the good-link output");
  chk_force_link: assert property (force_good_link |=> link_up)
    else $error("forced link not reported");
  chk_level_drop: assert property (s_no_level |-> !link_up)
    else $error("link stayed up without a valid level");
  chk_pulse_single: assert property (descrambler_timeout |=> !descrambler_timeout)
    else $error("timeout pulse longer than one cycle");
  chk_unlock_quiet: assert property (!descrambler_locked [*2] |-> !descrambler_timeout)
    else $error("timeout while unlocked");
  chk_sync_restart: assert property (descrambler_sync_seen |=> !descrambler_timeout [*8])
    else $error("timeout soon after a sync");
endmodule // pcs_cfg_checker

// ==== tb/pcs_config_status_register_tb_top.sv ====
`timescale 1ns/10ps
`include "pcs_cfg_defs.svh"
module pcs_config_status_register_tb_top;
  import pcs_cfg_pkg::*;
  localparam int unsigned SHORT_C = 20;
  localparam int unsigned LONG_C  = 50;
  localparam logic [31:0] ADDR    = 32'(`PCS_CFG_ADDR);
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        fiber_strap, external_force_link_input, signal_level_valid;
  logic        descrambler_locked, descrambler_sync_seen, force_good_link;
  logic        link_up, descrambler_timeout;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] v;
  pcs_ctrl_t   pcs_ctrl;
  int          failures, n_compared, seed, n;

  pcs_config_status_register #(.DESC_SHORT_CYC(SHORT_C), .DESC_LONG_CYC(LONG_C)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fiber_strap, .external_force_link_input, .signal_level_valid,
    .descrambler_locked, .descrambler_sync_seen, .pcs_ctrl, .force_good_link,
    .link_up, .descrambler_timeout);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] exp_reset(input logic s);
    return `PCS_RESET_VALUE | (s ? `PCS_STRAP_MASK : 16'h0);
  endfunction
  function automatic pcs_ctrl_t exp_ctrl(input logic [15:0] r);
    return {r[11], r[10], r[9], r[6], r[3], r[2], r[1], r[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50)
      failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic s);
    presetn <= 1'b0;
    fiber_strap <= s;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Counts edges up to the next timeout pulse.
  task automatic wait_pulse;
    n = 1;
    @(posedge pclk);
    while (descrambler_timeout !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Clock at 200 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Watchdog against a hung handshake.
  initial
  begin
    repeat (6000) @(posedge pclk);
    failures++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'h9df0;
    {presetn, psel, penable, pwrite, fiber_strap, external_force_link_input} = '0;
    {signal_level_valid, descrambler_locked, descrambler_sync_seen} = '0;
    {paddr, pwdata} = '0;
    for (int s = 0; s < 2; s++)
    begin
      do_reset(s[0]);
      apb(1'b0, ADDR, 32'h0);
      check(rd, {16'h0, exp_reset(s[0])});
      check({24'h0, pcs_ctrl}, {24'h0, exp_ctrl(exp_reset(s[0]))});
    end
    $display("test reset done");
    for (int i = 0; i < 10; i++)
    begin
      // upper four bits always written zero
      v = (i == 0) ? 16'h0FFF : 16'($random(seed)) & 16'h0FFF;
      apb(1'b1, ADDR, {16'hFFFF, v});
      check({31'h0, err}, 32'h0);
      apb(1'b0, ADDR, 32'h0);
      check(rd, {16'h0, v & `PCS_WRITE_MASK});
      check({24'h0, pcs_ctrl}, {24'h0, exp_ctrl(v)});
    end
    apb(1'b1, 32'h5C, 32'hFFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 32'h5C, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, ADDR, 32'h0);
    check(rd, {16'h0, v & `PCS_WRITE_MASK});
    // soft reset after a fiber change lies outside this block
    $display("test register done");
    apb(1'b1, ADDR, 32'h0020);
    repeat (3) @(posedge pclk);
    check({31'h0, link_up}, 32'h1);
    apb(1'b1, ADDR, 32'h0000);
    external_force_link_input <= 1'b1;
    repeat (8) @(posedge pclk);
    check({31'h0, force_good_link}, 32'h1);
    external_force_link_input <= 1'b0;
    repeat (8) @(posedge pclk);
    check({31'h0, link_up}, 32'h0);
    $display("test force done");
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, ADDR, (m == 2) ? 32'h0300 : {23'h0, m[0], 8'h0});
      signal_level_valid <= (m != 2);
      descrambler_locked <= 1'b1;
      repeat (4) @(posedge pclk);
      check({31'h0, link_up}, 32'h1);
      descrambler_locked <= 1'b0;
      repeat (4) @(posedge pclk);
      check({31'h0, link_up}, {31'h0, m != 0});
      signal_level_valid <= 1'b0;
      apb(1'b1, ADDR, 32'h0100);
      repeat (4) @(posedge pclk);
      check({31'h0, link_up}, 32'h0);
    end
    $display("test link done");
    for (int t = 0; t < 2; t++)
    begin
      apb(1'b1, ADDR, {24'h0, t[0], 7'h0});
      descrambler_locked <= 1'b1;
      descrambler_sync_seen <= 1'b1;
      @(posedge pclk);
      descrambler_sync_seen <= 1'b0;
      wait_pulse();
      wait_pulse();
      check(32'(n), t ? LONG_C : SHORT_C);
      descrambler_locked <= 1'b0;
    end
    $display("test timeout done");
    test_done();
  end
endmodule // pcs_config_status_register_tb_top

bind pcs_config_status_register pcs_cfg_checker #(
  .DESC_SHORT_CYC(DESC_SHORT_CYC), .DESC_LONG_CYC(DESC_LONG_CYC)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .fiber_strap, .external_force_link_input, .signal_level_valid,
  .descrambler_locked, .descrambler_sync_seen, .pcs_ctrl, .force_good_link,
  .link_up, .descrambler_timeout);
